// ### hdl/isc_pkg.sv
/*
 * Constants for the stop-condition generator of the serial bus interface:
 * register indices, field positions, reset values and bus timing counts.
 * Assumes a 100 MHz ref_clk and a plain address/strobe register port.
 */
package isc_pkg;
	// clock period and bus timing, in ns
	localparam int CLK_PERIOD_NS = 10;
	localparam int LOW_TIME_NS   = 4700;
	localparam int SETUP_TIME_NS = 4000;
	// low time rounds up, setup time rounds up (both least times)
	localparam logic [9:0] LOW_CYC   = 10'((LOW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [9:0] SETUP_CYC = 10'((SETUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// register byte addresses
	localparam logic [7:0] ADDR_CTRL  = 8'h00;
	localparam logic [7:0] ADDR_STAT  = 8'h04;
	localparam logic [7:0] ADDR_ISTAT = 8'h08;
	localparam logic [7:0] ADDR_IMASK = 8'h0C;

	// interface_control_register fields
	localparam int CTRL_STOP_TRIGGER  = 0;
	localparam int CTRL_START_TRIGGER = 1;
	localparam int CTRL_ACK_GEN_EN    = 2;
	localparam int CTRL_WAIT_TIMING   = 3;
	localparam int CTRL_WAIT_RELEASE  = 5;
	localparam int CTRL_EXIT_COMM     = 6;
	localparam int CTRL_IF_ENABLE     = 7;

	// interface_status_register fields
	localparam int STAT_STOP_SEEN  = 0;
	localparam int STAT_STOP_BUSY  = 1;
	localparam int STAT_TRANSMIT   = 3;
	localparam int STAT_MASTER     = 7;

	// interrupt status / mask fields
	localparam int IRQ_STOP_SEEN = 0;
	localparam int IRQ_ABORTED   = 1;
	localparam int IRQ_WAIT_CANC = 2;

	localparam logic [7:0] CTRL_RESET  = 8'h00;
	localparam logic [2:0] IRQ_RESET   = 3'h0;
endpackage

// ### hdl/isc_stop_trigger.sv
/*
 * Stop-condition generator of the serial bus interface with its register
 * port, pin synchronisers and interrupt logic.
 * Assumes open-drain clock and data pins resolved outside, and a byte
 * engine that reports wait periods, arbitration loss and master mode.
 */
// Operation
// - stop trigger drives data low, frees clock, after setup raises data.
// - eighth-clock wait trigger makes the stop in the ninth clock high period.
// - a detected stop condition clears the stop trigger.
// - arbitration loss, exit request, disable and reset clear the trigger.
// - wait release in ninth clock with transmit status set cancels wait.
// - the stop trigger bit always reads back as zero.
// - exit request and interface enable are control bits 6 and 7.
`timescale 1ns/1ps
`default_nettype none
module isc_stop_trigger (
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst,
	// register port
	input  wire logic [7:0] regAddr,
	input  wire logic [7:0] regWdata,
	input  wire logic       regWr,
	input  wire logic       regRd,
	output logic      [7:0] regRdata,
	// byte engine status
	input  wire logic       masterMode,
	input  wire logic       arbLost,
	input  wire logic       txStatusSet,
	input  wire logic       eighthWait,
	input  wire logic       ninthWait,
	output logic            waitRelease,
	// serial_clock_pin
	input  wire logic       sclIn,
	output logic            sclOut,
	output logic            sclOe_n,
	// serial_data_pin
	input  wire logic       sdaIn,
	output logic            sdaOut,
	output logic            sdaOe_n,
	// interrupt
	output logic            irq
);
	typedef enum logic [2:0] {ST_IDLE, ST_DATA_LOW, ST_CLK_HIGH, ST_SETUP, ST_DATA_HIGH} isc_state_t;

	isc_state_t  stopFsm_ff;
	isc_state_t  nxt_stopFsm;
	logic [9:0]  tmr_ff;
	logic        stopTrig_ff;
	logic        ifEnable_ff;
	logic        ackGen_ff;
	logic        waitTiming_ff;
	logic        txStatus_ff;
	logic        stopSeen_ff;
	logic        sdaDrive_ff;
	logic        sclDrive_ff;
	logic        waitRelease_ff;
	logic [7:0]  rdata_ff;
	logic [2:0]  irqStat_ff;
	logic [2:0]  irqMask_ff;
	logic [2:0]  sclSync_ff;
	logic [2:0]  sdaSync_ff;
	logic        sclF_ff;
	logic        sdaF_ff;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
		hit = (a == ref_a);
	endfunction

	logic ctrlWr;
	logic stopSet;
	logic exitReq;
	logic abortReq;
	logic stopDet;
	logic waitCancel;
	logic [2:0] irqEvt;

	assign ctrlWr     = regWr && hit(regAddr, isc_pkg::ADDR_CTRL);
	assign stopSet    = ctrlWr && ifEnable_ff && regWdata[isc_pkg::CTRL_STOP_TRIGGER];
	assign exitReq    = ctrlWr && regWdata[isc_pkg::CTRL_EXIT_COMM];
	assign abortReq   = arbLost || exitReq || !ifEnable_ff;
	assign waitCancel = ctrlWr && regWdata[isc_pkg::CTRL_WAIT_RELEASE] && txStatus_ff && ninthWait;
	// data rising while clock high is a stop condition
	assign stopDet    = sclF_ff && sclSync_ff[1] && sclSync_ff[2] && !sdaF_ff
		&& sdaSync_ff[1] && sdaSync_ff[2];

	// pin synchronisers: filtered level follows once stages two and three agree
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sclSync_ff <= 3'h7;
			sdaSync_ff <= 3'h7;
		end else begin
			sclSync_ff <= {sclSync_ff[1:0], sclIn};
			sdaSync_ff <= {sdaSync_ff[1:0], sdaIn};
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sclF_ff <= 1'b1;
			sdaF_ff <= 1'b1;
		end else begin
			if (sclSync_ff[1] == sclSync_ff[2]) begin
				sclF_ff <= sclSync_ff[2];
			end
			if (sdaSync_ff[1] == sdaSync_ff[2]) begin
				sdaF_ff <= sdaSync_ff[2];
			end
		end
	end

	// control bits; exit request and wait release are write-only pulses
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ifEnable_ff   <= isc_pkg::CTRL_RESET[isc_pkg::CTRL_IF_ENABLE];
			ackGen_ff     <= isc_pkg::CTRL_RESET[isc_pkg::CTRL_ACK_GEN_EN];
			waitTiming_ff <= isc_pkg::CTRL_RESET[isc_pkg::CTRL_WAIT_TIMING];
		end else if (ctrlWr) begin
			ifEnable_ff   <= regWdata[isc_pkg::CTRL_IF_ENABLE];
			ackGen_ff     <= regWdata[isc_pkg::CTRL_ACK_GEN_EN];
			waitTiming_ff <= regWdata[isc_pkg::CTRL_WAIT_TIMING];
		end
	end

	// stop trigger: set by software, cleared by stop or abort
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			stopTrig_ff <= 1'b0;
		end else if (abortReq || stopDet) begin
			stopTrig_ff <= 1'b0;
		end else if (stopSet) begin
			stopTrig_ff <= 1'b1;
		end
	end

	// transmit status cleared by wait release in the ninth-clock wait
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			txStatus_ff    <= 1'b0;
			waitRelease_ff <= 1'b0;
		end else begin
			waitRelease_ff <= waitCancel;
			if (txStatusSet) begin
				txStatus_ff <= 1'b1;
			end else if (waitCancel || !ifEnable_ff) begin
				txStatus_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			stopSeen_ff <= 1'b0;
		end else if (stopDet) begin
			stopSeen_ff <= 1'b1;
		end else if (hit(regAddr, isc_pkg::ADDR_STAT) && regRd) begin
			stopSeen_ff <= 1'b0;
		end
	end

	// stop sequence: data low, clock free, setup time, data high
	always_comb begin
		nxt_stopFsm = stopFsm_ff;
		case (stopFsm_ff)
			ST_IDLE: begin
				if (stopTrig_ff && !abortReq) begin
					nxt_stopFsm = ST_DATA_LOW;
				end
			end
			ST_DATA_LOW: begin
				if (tmr_ff == isc_pkg::LOW_CYC - 10'h001) begin
					nxt_stopFsm = ST_CLK_HIGH;
				end
			end
			ST_CLK_HIGH: begin
				if (sclF_ff) begin
					nxt_stopFsm = ST_SETUP;
				end
			end
			ST_SETUP: begin
				if (tmr_ff == isc_pkg::SETUP_CYC - 10'h001) begin
					nxt_stopFsm = ST_DATA_HIGH;
				end
			end
			ST_DATA_HIGH: begin
				if (stopDet) begin
					nxt_stopFsm = ST_IDLE;
				end
			end
			default: begin
				nxt_stopFsm = ST_IDLE;
			end
		endcase
		if (abortReq || !stopTrig_ff) begin
			nxt_stopFsm = ST_IDLE;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			stopFsm_ff <= ST_IDLE;
		end else begin
			stopFsm_ff <= nxt_stopFsm;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			tmr_ff <= 10'h000;
		end else if (nxt_stopFsm != stopFsm_ff) begin
			tmr_ff <= 10'h000;
		end else begin
			tmr_ff <= tmr_ff + 10'h001;
		end
	end

	// eighth-clock wait: releasing the clock here yields the ninth clock high
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sdaDrive_ff <= 1'b0;
			sclDrive_ff <= 1'b0;
		end else begin
			sdaDrive_ff <= (nxt_stopFsm == ST_DATA_LOW) || (nxt_stopFsm == ST_CLK_HIGH)
				|| (nxt_stopFsm == ST_SETUP);
			sclDrive_ff <= (nxt_stopFsm == ST_DATA_LOW);
		end
	end

	// interrupts: set wins over write-one clear
	assign irqEvt = {waitCancel, stopTrig_ff && abortReq && !stopDet, stopDet};

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			irqStat_ff <= isc_pkg::IRQ_RESET;
			irqMask_ff <= isc_pkg::IRQ_RESET;
		end else begin
			if (regWr && hit(regAddr, isc_pkg::ADDR_ISTAT)) begin
				irqStat_ff <= (irqStat_ff & ~regWdata[2:0]) | irqEvt;
			end else begin
				irqStat_ff <= irqStat_ff | irqEvt;
			end
			if (regWr && hit(regAddr, isc_pkg::ADDR_IMASK)) begin
				irqMask_ff <= regWdata[2:0];
			end
		end
	end

	// read data, one cycle after the strobe; triggers and pulses read zero
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rdata_ff <= 8'h00;
		end else if (!regRd) begin
			rdata_ff <= 8'h00;
		end else if (hit(regAddr, isc_pkg::ADDR_CTRL)) begin
			rdata_ff <= {ifEnable_ff, 3'h0, waitTiming_ff, ackGen_ff, 2'h0};
		end else if (hit(regAddr, isc_pkg::ADDR_STAT)) begin
			rdata_ff <= {masterMode, 3'h0, txStatus_ff, 1'b0, stopTrig_ff, stopSeen_ff};
		end else if (hit(regAddr, isc_pkg::ADDR_ISTAT)) begin
			rdata_ff <= {5'h00, irqStat_ff};
		end else if (hit(regAddr, isc_pkg::ADDR_IMASK)) begin
			rdata_ff <= {5'h00, irqMask_ff};
		end else begin
			rdata_ff <= 8'h00;
		end
	end

	assign regRdata    = rdata_ff;
	assign waitRelease = waitRelease_ff;
	assign irq         = |(irqStat_ff & irqMask_ff);
	assign sclOut      = 1'b0;
	assign sdaOut      = 1'b0;
	assign sclOe_n     = !sclDrive_ff;
	assign sdaOe_n     = !sdaDrive_ff;

	// check helper: cycles of data held low under a high filtered clock
	logic [9:0]  setupCnt_ff;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			setupCnt_ff <= 10'h000;
		end else if (sdaOe_n || !sclF_ff) begin
			setupCnt_ff <= 10'h000;
		end else if (setupCnt_ff != 10'h3FF) begin
			setupCnt_ff <= setupCnt_ff + 10'h001;
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	AST_SEQ_SETUP_DRIVE: assert property (
		(stopFsm_ff == ST_SETUP) |-> (!sdaOe_n && sclOe_n))
		else $error("data not held low with clock free during setup");
	AST_SEQ_SETUP_TIME: assert property (
		($rose(sdaOe_n) && stopFsm_ff == ST_DATA_HIGH) |->
		(setupCnt_ff >= isc_pkg::SETUP_CYC))
		else $error("data released before setup time");
	AST_EIGHTH_CLOCK: assert property (
		($rose(stopTrig_ff) && eighthWait && !waitTiming_ff && !abortReq) |->
		##[1:480] ((sclOe_n && !sdaOe_n) || !stopTrig_ff))
		else $error("ninth clock not released with data low");
	AST_CLEAR_ON_STOP: assert property (
		stopDet |=> !stopTrig_ff)
		else $error("stop trigger survives a detected stop");
	AST_CLEAR_ON_ABORT: assert property (
		(arbLost || exitReq || !ifEnable_ff) |=> (!stopTrig_ff && stopFsm_ff == ST_IDLE))
		else $error("stop trigger survives an abort");
	AST_WAIT_CANCEL: assert property (
		waitCancel |=> (!txStatus_ff || $past(txStatusSet)) && waitRelease && sdaOe_n)
		else $error("wait release did not cancel transmit status");
	AST_READ_ZERO: assert property (
		(regRd && hit(regAddr, isc_pkg::ADDR_CTRL)) |=> !regRdata[0])
		else $error("stop trigger read back as one");
	AST_ENABLE_BIT7: assert property (
		(regRd && hit(regAddr, isc_pkg::ADDR_CTRL)) |=>
		(regRdata[7] == $past(ifEnable_ff)) && !regRdata[6])
		else $error("enable not on bit 7 of control");

	COV_STOP_DONE: cover property ($fell(stopTrig_ff) && stopSeen_ff);
	COV_ABORT: cover property ((stopFsm_ff == ST_DATA_LOW) ##1 (stopFsm_ff == ST_IDLE && !stopSeen_ff));
	COV_WAIT_CANCEL: cover property (waitCancel);
endmodule
`default_nettype wire

// ### testbench/isc_bus_partner.sv
/*
 * Far-side bus device: pull-ups on clock and data, and clock stretching.
 * Assumes the enables are low while the generator pulls a line low.
 */
`timescale 1ns/1ps
`default_nettype none
module isc_bus_partner (
	// clock
	input  wire logic       ref_clk,
	// generator side
	input  wire logic       sclOe_n,
	input  wire logic       sdaOe_n,
	input  wire logic [3:0] stretch,
	// resolved lines
	output logic            sclIn,
	output logic            sdaIn
);
	logic [3:0] holdCnt;
	initial holdCnt = 4'h0;
	// slow slave: keeps the clock low a while after it is freed
	always @(posedge ref_clk) begin
		if (sclOe_n == 1'b0)
			holdCnt <= stretch;
		else if (holdCnt != 4'h0)
			holdCnt <= holdCnt - 4'h1;
	end
	// released lines go to the pull-up level
	assign sclIn = sclOe_n & (holdCnt == 4'h0);
	assign sdaIn = sdaOe_n;
endmodule
`default_nettype wire

// ### testbench/test_isc_stop_trigger.sv
/*
 * Self-checking bench for the stop-condition generator.
 * Assumes the partner model resolves both open-drain lines.
 */
`timescale 1ns/1ps
`default_nettype none
module test_isc_stop_trigger;
	localparam logic [7:0] A_CT = isc_pkg::ADDR_CTRL;
	localparam logic [7:0] A_ST = isc_pkg::ADDR_STAT;
	localparam logic [7:0] A_IS = isc_pkg::ADDR_ISTAT;
	localparam logic [7:0] A_IM = isc_pkg::ADDR_IMASK;
	logic        ref_clk = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0, rdLate = 1'b0;
	logic [7:0]  regAddr = 8'h00, regWdata = 8'h00, regRdata, rv;
	logic        masterMode = 1'b0, arbLost = 1'b0, txStatusSet = 1'b0;
	logic        eighthWait = 1'b0, ninthWait = 1'b0, waitRelease, irq;
	logic        sclIn, sclOut, sclOe_n, sdaIn, sdaOut, sdaOe_n;
	logic [3:0]  stretch = 4'h3;
	logic [15:0] expQ[$];
	int          mismatches = 0, total_checks = 0, cyc = 0, n, t0;

	isc_stop_trigger i_isc_stop_trigger (.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
		.masterMode(masterMode), .arbLost(arbLost), .txStatusSet(txStatusSet),
		.eighthWait(eighthWait), .ninthWait(ninthWait), .waitRelease(waitRelease),
		.sclIn(sclIn), .sclOut(sclOut), .sclOe_n(sclOe_n), .sdaIn(sdaIn),
		.sdaOut(sdaOut), .sdaOe_n(sdaOe_n), .irq(irq));
	isc_bus_partner i_isc_bus_partner (.ref_clk(ref_clk), .sclOe_n(sclOe_n),
		.sdaOe_n(sdaOe_n), .stretch(stretch), .sclIn(sclIn), .sdaIn(sdaIn));

	always #5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		rdLate <= regRd;
		cyc <= cyc + 1;
	end
	// read data stands in the cycle after the strobe
	always @(negedge ref_clk) begin
		if (rdLate) begin
			total_checks++;
			if (expQ.size() == 0 || (regRdata & expQ[0][15:8]) !== expQ[0][7:0]) begin
				mismatches++;
				$display("ERROR %0t read data %h unexpected", $time, regRdata);
			end
			if (expQ.size() != 0)
				void'(expQ.pop_front());
		end
	end

	task automatic cmpBit(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t flag %b expected %b", $time, got, exp);
		end
	endtask
	task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge ref_clk);
		regWr <= 1'b0;
	endtask
	task automatic rdReg(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		@(posedge ref_clk);
		regRd <= 1'b1;
		regAddr <= a;
		expQ.push_back({m, e & m});
		@(posedge ref_clk);
		regRd <= 1'b0;
	endtask
	task automatic pulse(input int which);
		@(posedge ref_clk);
		if (which == 0) arbLost <= 1'b1; else txStatusSet <= 1'b1;
		@(posedge ref_clk);
		arbLost <= 1'b0;
		txStatusSet <= 1'b0;
	endtask
	// waits for scl enable (0), sda enable (1) or irq (2) to reach lvl
	task automatic waitFor(input int sel, input logic lvl);
		n = 0;
		while ((sel == 0 ? sclOe_n : sel == 1 ? sdaOe_n : irq) !== lvl && n < 3000) begin
			@(posedge ref_clk);
			n++;
		end
		if (n >= 3000) begin
			mismatches++;
			$display("ERROR %0t wait ran out", $time);
			results();
		end
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		void'($urandom(32'h9A53));
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		rdReg(A_CT, 8'hFF, isc_pkg::CTRL_RESET);
		cmpBit(sdaOe_n & sclOe_n, 1'b1);
		cmpBit(sclOut | sdaOut, 1'b0);
		wrReg(8'h10, 8'hFF);
		rdReg(8'h10, 8'hFF, 8'h00);
		wrReg(A_CT, 8'h01);
		rdReg(A_ST, 8'h02, 8'h00);
		masterMode <= 1'b1;
		eighthWait <= 1'b1;
		wrReg(A_CT, 8'h8E);
		rdReg(A_CT, 8'hFF, 8'h8C);
		wrReg(A_IM, 8'h07);
		wrReg(A_CT, 8'h81);
		t0 = cyc;
		rdReg(A_CT, 8'hFF, 8'h80);
		rdReg(A_ST, 8'h82, 8'h82);
		waitFor(1, 1'b0);
		waitFor(0, 1'b1);
		cmpBit(cyc - t0 >= isc_pkg::LOW_CYC, 1'b1);
		t0 = cyc;
		waitFor(1, 1'b1);
		cmpBit(sclIn, 1'b1);
		cmpBit(cyc - t0 >= isc_pkg::SETUP_CYC, 1'b1);
		waitFor(2, 1'b1);
		rdReg(A_ST, 8'h83, 8'h81);
		rdReg(A_IS, 8'h07, 8'h01);
		wrReg(A_IS, 8'h01);
		@(negedge ref_clk);
		cmpBit(irq, 1'b0);
		for (int k = 0; k < 3; k++) begin
			eighthWait <= 1'($urandom_range(0, 1));
			wrReg(A_CT, 8'h80);
			wrReg(A_CT, 8'h81);
			repeat ($urandom_range(1, 8)) @(posedge ref_clk);
			if (k == 0) pulse(0);
			else wrReg(A_CT, k == 1 ? 8'hC0 : 8'h00);
			rdReg(A_ST, 8'h02, 8'h00);
			rdReg(A_IS, 8'h02, 8'h02);
			wrReg(A_IS, 8'h07);
		end
		wrReg(A_CT, 8'h80);
		ninthWait <= 1'b1;
		pulse(1);
		rdReg(A_ST, 8'h08, 8'h08);
		rv = 8'($urandom_range(0, 3));
		wrReg(A_IM, rv);
		rdReg(A_IM, 8'hFF, rv);
		wrReg(A_CT, 8'hA0);
		n = 0;
		repeat (4) begin
			@(negedge ref_clk);
			n += int'(waitRelease === 1'b1);
		end
		cmpBit(n == 1, 1'b1);
		rdReg(A_ST, 8'h08, 8'h00);
		rdReg(A_IS, 8'h04, 8'h04);
		@(negedge ref_clk);
		cmpBit(irq, 1'b0);
		wrReg(A_IM, 8'h04);
		@(negedge ref_clk);
		cmpBit(irq, 1'b1);
		wrReg(A_IS, 8'h04);
		@(negedge ref_clk);
		cmpBit(irq, 1'b0);
		repeat (4) @(posedge ref_clk);
		results();
	end
endmodule
`default_nettype wire
